// [rtl/rmsc_top.sv]
/*
 Reset entry and mode strap capture for a 16-bit embedded processor.
 Assumes board logic drives the reset pin and strap pins; pull-ups are outside.
*/
`timescale 1ns/1ns
`default_nettype none
module rmsc_top
    import rmsc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic reset_in_n,
    input  wire logic upper_select_strap,
    input  wire logic lower_select_strap,
    input  wire logic queue_status_strap,
    input  wire logic coproc_busy_strap,
    input  wire logic bus_lock_strap,
    input  wire logic bus_cycle_active,
    output var  logic core_reset,
    output var  logic strap_pullup_en,
    output var  logic bus_ctrl_inactive,
    output var  logic bus_ctrl_oe,
    output var  logic tristate_test_mode,
    output var  logic queue_status_mode,
    output var  logic coproc_mode,
    output var  logic bus_abort
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [5:0] pins_sync;
    logic       res_s;
    logic       ucs_s;
    logic       lcs_s;
    logic       qs_s;
    logic       busy_s;
    logic       lock_s;

    rmsc_sync #(.WIDTH(6)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      ({reset_in_n, upper_select_strap, lower_select_strap,
                    queue_status_strap, coproc_busy_strap, bus_lock_strap}),
        .dout     (pins_sync)
    );

    assign {res_s, ucs_s, lcs_s, qs_s, busy_s, lock_s} = pins_sync;

    // ---------------------------------------------------------------
    // Reset sequencing and mode capture
    // ---------------------------------------------------------------
    rmsc_state_t state;
    rmsc_state_t next_state;
    logic [2:0]  cnt;
    logic [2:0]  next_cnt;
    logic        busy_at_rise;
    logic        next_busy_at_rise;
    logic        abort_pend;
    logic        next_abort_pend;
    logic        next_tristate_test_mode;
    logic        next_queue_status_mode;
    logic        next_coproc_mode;

    always_comb begin
        next_state              = state;
        next_cnt                = cnt;
        next_busy_at_rise       = busy_at_rise;
        next_abort_pend         = 1'b0;
        next_tristate_test_mode = tristate_test_mode;
        next_queue_status_mode  = queue_status_mode;
        next_coproc_mode        = coproc_mode;
        case (state)
            RMSC_ST_RESET: begin
                next_cnt = CNT_RESET;
                if (res_s) begin
                    next_tristate_test_mode = !ucs_s && !lcs_s;
                    next_queue_status_mode  = !qs_s;
                    next_busy_at_rise       = busy_s;
                    next_coproc_mode        = MODE_RESET;
                    next_state              = RMSC_ST_WATCH;
                end
            end
            RMSC_ST_WATCH: begin
                next_cnt = cnt + 3'h1;
                if (cnt + 3'h1 == COPROC_CNT_W3) begin
                    next_coproc_mode = busy_at_rise && !busy_s;
                    next_state       = RMSC_ST_RUN;
                end
            end
            RMSC_ST_RUN: begin
                next_state = RMSC_ST_RUN;
            end
            default: begin
                next_state = RMSC_ST_RESET;
            end
        endcase
        if (!res_s) begin
            next_state      = RMSC_ST_RESET;
            next_abort_pend = state != RMSC_ST_RESET && bus_cycle_active;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state              <= RMSC_ST_RESET;
            cnt                <= CNT_RESET;
            busy_at_rise       <= MODE_RESET;
            abort_pend         <= MODE_RESET;
            tristate_test_mode <= MODE_RESET;
            queue_status_mode  <= MODE_RESET;
            coproc_mode        <= MODE_RESET;
        end else begin
            state              <= next_state;
            cnt                <= next_cnt;
            busy_at_rise       <= next_busy_at_rise;
            abort_pend         <= next_abort_pend;
            tristate_test_mode <= next_tristate_test_mode;
            queue_status_mode  <= next_queue_status_mode;
            coproc_mode        <= next_coproc_mode;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_comb begin
        core_reset        = state == RMSC_ST_RESET;
        strap_pullup_en   = state == RMSC_ST_RESET;
        bus_abort         = abort_pend;
        bus_ctrl_inactive = state == RMSC_ST_RESET;
        bus_ctrl_oe       = state != RMSC_ST_RESET || abort_pend;
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_reset_follows;
        @(posedge core_clk) disable iff (!rst_n) !res_s |=> core_reset;
    endproperty
    a_reset_follows: assert property (p_reset_follows) else $error("Reset not applied.");

    property p_sync_lat;
        @(posedge core_clk) disable iff (!rst_n)
            $fell(reset_in_n) ##0 !reset_in_n [*3] |=> core_reset;
    endproperty
    a_sync_lat: assert property (p_sync_lat) else $error("Reset sync latency wrong.");

    property p_sync_early;
        @(posedge core_clk) disable iff (!rst_n)
            (state == RMSC_ST_RUN && $fell(reset_in_n)) |=> !core_reset;
    endproperty
    a_sync_early: assert property (p_sync_early) else $error("Reset taken before synchroniser.");

    property p_stop;
        @(posedge core_clk) disable iff (!rst_n)
            (state == RMSC_ST_RUN && !res_s) |=> state == RMSC_ST_RESET;
    endproperty
    a_stop: assert property (p_stop) else $error("Activity not stopped.");

    property p_abort;
        @(posedge core_clk) disable iff (!rst_n)
            (state == RMSC_ST_RUN && !res_s && bus_cycle_active) |=> bus_abort && bus_ctrl_oe ##1 !bus_ctrl_oe;
    endproperty
    a_abort: assert property (p_abort) else $error("Bus abort sequence wrong.");

    property p_no_abort;
        @(posedge core_clk) disable iff (!rst_n)
            (state == RMSC_ST_RUN && !res_s && !bus_cycle_active) |=> !bus_abort && !bus_ctrl_oe;
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("Abort without bus cycle.");

    property p_pullup;
        @(posedge core_clk) disable iff (!rst_n) !res_s |=> strap_pullup_en && bus_ctrl_inactive;
    endproperty
    a_pullup: assert property (p_pullup) else $error("Pull-ups off in reset.");

    property p_tst;
        @(posedge core_clk) disable iff (!rst_n)
            (state == RMSC_ST_RESET && res_s) |=> tristate_test_mode == (!$past(ucs_s) && !$past(lcs_s));
    endproperty
    a_tst: assert property (p_tst) else $error("Test mode capture wrong.");

    property p_qs;
        @(posedge core_clk) disable iff (!rst_n)
            (state == RMSC_ST_RESET && res_s) |=> queue_status_mode == !$past(qs_s);
    endproperty
    a_qs: assert property (p_qs) else $error("Queue mode capture wrong.");

    property p_cop;
        @(posedge core_clk) disable iff (!rst_n)
            (state == RMSC_ST_RESET && res_s && busy_s) ##1 res_s [*3] ##1 (res_s && !busy_s) |=> coproc_mode;
    endproperty
    a_cop: assert property (p_cop) else $error("Coprocessor mode missed.");

    property p_cop_off;
        @(posedge core_clk) disable iff (!rst_n)
            (state == RMSC_ST_RESET && res_s && !busy_s) |=> ##4 !coproc_mode;
    endproperty
    a_cop_off: assert property (p_cop_off) else $error("Coprocessor mode without busy strap.");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
            (state == RMSC_ST_RUN && res_s) |=> $stable(tristate_test_mode) && $stable(queue_status_mode)
                && $stable(coproc_mode);
    endproperty
    a_hold: assert property (p_hold) else $error("Mode changed without reset.");

    c_run:   cover property (@(posedge core_clk) disable iff (!rst_n) state == RMSC_ST_RUN);
    c_cop:   cover property (@(posedge core_clk) disable iff (!rst_n) coproc_mode);
    c_tst:   cover property (@(posedge core_clk) disable iff (!rst_n) tristate_test_mode && queue_status_mode);
    c_abort: cover property (@(posedge core_clk) disable iff (!rst_n) bus_abort);
    c_qs:    cover property (@(posedge core_clk) disable iff (!rst_n) queue_status_mode && !tristate_test_mode);
endmodule // rmsc_top
`default_nettype wire

// [rtl/rmsc_pkg.sv]
/*
 Constants for the reset and mode strap capture block.
 Assumes a single 20 MHz core clock and an active-low asynchronous reset.
*/
`default_nettype none
package rmsc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SYNC_STAGES   = 2;
    // Clocks between the reset pin release and the coprocessor-busy strap fall.
    localparam int unsigned COPROC_DELAY  = 4;
    localparam logic [2:0]  COPROC_CNT_W3 = 3'h4;
    localparam logic        MODE_RESET    = 1'b0;
    localparam logic [2:0]  CNT_RESET     = 3'h0;

    typedef enum logic [1:0] {
        RMSC_ST_RESET = 2'b00,
        RMSC_ST_WATCH = 2'b01,
        RMSC_ST_RUN   = 2'b10
    } rmsc_state_t;
endpackage
`default_nettype wire

// [rtl/rmsc_sync.sv]
/*
 Two-flop synchroniser bank for pin inputs.
 Assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module rmsc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule // rmsc_sync
`default_nettype wire

// [tb/rmsc_board.sv]
/*
 Board model: external reset circuit and mode strap drivers.
 Assumes the bench calls drive_reset and the strap pins have pull-ups.
*/
`timescale 1ns/1ns
`default_nettype none
module rmsc_board
    import rmsc_pkg::*;
(
    input  wire logic core_clk,
    output var  logic reset_in_n,
    output var  logic upper_select_strap,
    output var  logic lower_select_strap,
    output var  logic queue_status_strap,
    output var  logic coproc_busy_strap,
    output var  logic bus_lock_strap
);
    // ------------------------------------------------------------
    // Reset held from power-on, straps at their pulled-up level.
    // ------------------------------------------------------------
    initial begin
        reset_in_n = 1'b0;
        {upper_select_strap, lower_select_strap, queue_status_strap, coproc_busy_strap} = 4'hF;
        bus_lock_strap = 1'b1;
    end

    // One reset pulse; bsel 0 keeps busy high, 1 drops it later, 2 holds it low.
    task automatic drive_reset(input logic u, input logic l, input logic q, input logic [1:0] bsel);
        @(posedge core_clk);
        #5;
        reset_in_n = 1'b0;
        {upper_select_strap, lower_select_strap, queue_status_strap} = {u, l, q};
        coproc_busy_strap = (bsel != 2'h2);
        repeat (6) @(posedge core_clk);
        #5;
        reset_in_n = 1'b1;
        repeat (COPROC_DELAY) @(posedge core_clk);
        #5;
        if (bsel == 2'h1) coproc_busy_strap = 1'b0;
        {upper_select_strap, lower_select_strap, queue_status_strap} = 3'h7;
        repeat (3) @(posedge core_clk);
        #5;
        coproc_busy_strap = 1'b1;
    endtask
endmodule // rmsc_board
`default_nettype wire

// [tb/tb_top.sv]
/*
 Self-checking bench for the reset and mode strap capture block.
 Assumes the board model drives the pins and the bench drives the bus activity.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import rmsc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n    = 1'b0;
    logic bus_cycle_active = 1'b0;
    wire  logic rin_n, ups, lws, qss, cbs, bls;
    logic core_reset, pull_en, inact, oe, tmode, qmode, cmode, abrt;
    int   err_count = 0;
    int   compares  = 0;
    int   cycles    = 0;
    int   seed      = 32'hafe75083;
    logic [2:0] r;

    always #25 core_clk = ~core_clk;

    rmsc_board u_board (.core_clk(core_clk), .reset_in_n(rin_n), .upper_select_strap(ups),
        .lower_select_strap(lws), .queue_status_strap(qss), .coproc_busy_strap(cbs), .bus_lock_strap(bls));
    rmsc_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .reset_in_n(rin_n), .upper_select_strap(ups),
        .lower_select_strap(lws), .queue_status_strap(qss), .coproc_busy_strap(cbs),
        .bus_lock_strap(bls), .bus_cycle_active(bus_cycle_active), .core_reset(core_reset),
        .strap_pullup_en(pull_en), .bus_ctrl_inactive(inact), .bus_ctrl_oe(oe),
        .tristate_test_mode(tmode), .queue_status_mode(qmode), .coproc_mode(cmode), .bus_abort(abrt));

    // ------------------------------------------------------------
    // Checking helpers.
    // ------------------------------------------------------------
    task automatic check(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    function automatic logic [2:0] exp_modes(input logic u, input logic l, input logic q, input logic [1:0] b);
        return {~u & ~l, ~q, b == 2'h1};
    endfunction

    task automatic one_reset(input logic u, input logic l, input logic q, input logic [1:0] b);
        logic [2:0] e;
        e = exp_modes(u, l, q, b);
        u_board.drive_reset(u, l, q, b);
        repeat (4) @(posedge core_clk);
        #1;
        check(tmode, e[2], "test mode");
        check(qmode, e[1], "queue mode");
        check(cmode, e[0], "coproc mode");
        check(core_reset, 1'b0, "core reset released");
        check(oe, 1'b1, "bus drive after release");
    endtask

    task automatic close_out;
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        #5;
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check(core_reset, 1'b1, "held while pin low");
        check(pull_en, 1'b1, "strap pull-ups");
        check(inact, 1'b1, "controls inactive");
        check(oe, 1'b0, "controls floated");
        one_reset(1'b0, 1'b0, 1'b1, 2'h1);
        one_reset(1'b1, 1'b1, 1'b0, 2'h0);
        one_reset(1'b0, 1'b1, 1'b1, 2'h2);
        one_reset(1'b1, 1'b0, 1'b0, 2'h1);
        repeat (8) begin
            r = 3'($random(seed));
            one_reset(r[0], r[1], r[2], 2'($unsigned($random(seed)) % 3));
        end
        @(posedge core_clk);
        #5;
        bus_cycle_active = 1'b1;
        fork
            u_board.drive_reset(1'b0, 1'b0, 1'b0, 2'h1);
            begin
                @(negedge rin_n);
                repeat (2) @(posedge core_clk);
                #1;
                check(core_reset, 1'b0, "synchroniser lag");
                @(posedge core_clk);
                #1;
                check(core_reset, 1'b1, "reset taken");
                check(abrt, 1'b1, "bus cycle cut");
                check(inact & oe, 1'b1, "inactive before float");
                @(posedge core_clk);
                #1;
                check(abrt, 1'b0, "abort one cycle");
                check(oe, 1'b0, "controls float");
                check(pull_en, 1'b1, "pull-ups in reset");
                #4;
                bus_cycle_active = 1'b0;
            end
        join
        repeat (4) @(posedge core_clk);
        #5;
        check(tmode & qmode & cmode, 1'b1, "all modes held");
        rst_n = 1'b0;
        #1;
        check(tmode | qmode | cmode, 1'b0, "modes cleared by power reset");
        check(core_reset, 1'b1, "power reset");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
